// ===== logic/smsp_pkg.sv
package smsp_pkg;
  // register byte addresses
  localparam logic [31:0] STATUS_OFS = 32'hFFFF0A00;
  localparam logic [31:0] RX_OFS = 32'hFFFF0A04;
  localparam logic [31:0] TX_OFS = 32'hFFFF0A08;
  localparam logic [31:0] DIV_OFS = 32'hFFFF0A0C;
  localparam logic [31:0] CON_OFS = 32'hFFFF0A10;
  // control field positions
  localparam int CON_EN = 0;
  localparam int CON_MASTER = 1;
  localparam int CON_CPHA = 2;
  localparam int CON_CPOL = 3;
  localparam int CON_TXMODE = 6;
  localparam int CON_RFLUSH = 12;
  localparam int CON_TFLUSH = 13;
  localparam int CON_THR_LO = 14;
  localparam logic [15:0] CON_WMASK = 16'hF04F;
  // status field positions
  localparam int ST_ANY = 0;
  localparam int ST_TXLVL_LO = 1;
  localparam int ST_TXUF = 4;
  localparam int ST_TXIRQ = 5;
  localparam int ST_RXIRQ = 6;
  localparam int ST_OVF = 7;
  localparam int ST_RXLVL_LO = 8;
  localparam int ST_REX = 11;
  // reset values
  localparam logic [15:0] CON_RESET = 16'h0000;
  localparam logic [7:0] DIV_RESET = 8'h00;
  localparam logic [31:0] STATUS_RESET = 32'h00000000;
  // data path
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 4;
  localparam int FIFO_AW = 2;
  localparam int LVL_W = 3;
  localparam int DIV_W = 8;
  localparam logic [7:0] UNDERFLOW_BYTE = 8'h00;
  localparam logic [4:0] EDGES_PER_BYTE = 5'h10;
  // timing
  localparam int CORE_CLK_HZ = 20_000_000;
  localparam int MASTER_MAX_BPS = 20_000_000;
  localparam int SLAVE_MAX_BPS = 10_000_000;
  localparam int SLAVE_MIN_CYC_PER_BIT = CORE_CLK_HZ / SLAVE_MAX_BPS;
  typedef enum logic [1:0] {
    M_IDLE = 2'b00,
    M_XFER = 2'b01,
    M_GAP = 2'b10
  } smsp_mstate_e;
endpackage : smsp_pkg

// ===== logic/smsp_fifo_mem.sv
`timescale 1ns/10ps
module smsp_fifo_mem #(
  parameter int W = 8,
  parameter int DEPTH = 4,
  parameter int AW = 2
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [W-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [W-1:0] rd_data
);
  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule : smsp_fifo_mem

// ===== logic/smsp_port.sv
// Function
// - each byte shifts eight bits out and in together, most significant first
// - data-in line from slave is input as master, driven output as slave
// - data-out line to slave is driven output as master, input as slave
// - serial clock out as master, in as slave; eight periods per byte
// - master clock rate is core clock over 2 times (1 plus divider)
// - master bit rates up to 20 Mbps; the divider gives at most 10 Mbps from the 20 MHz core clock
// - slave accepts up to 10 Mbps; external master must not go faster
// - data launched on one clock edge, sampled on the other, per polarity/phase
// - slave transfer runs from chip select falling until it rises
// - master drives chip select low at start, high at completion
// - status bit 11 set while receive level exceeds threshold count
// - status bits 10:8 give receive level, zero to four
// - bit 7 flags byte arriving into full receive FIFO; cleared by read
// - bit 6 flags receive threshold reached when transmit mode off
// - bit 5 flags transmit threshold reached when transmit mode on
// - bit 4 flags transfer start with empty transmit FIFO
// - status bits 3:1 give transmit level, zero to four
// - bit 0 set by any interrupt source, cleared by status read; here underflow does not set it while transmit flush is set
// - two-bit threshold selects one to four bytes
// - transmit flush empties FIFO and ignores writes while set
// - receive flush empties FIFO, drops bytes, blocks interrupts while set
//
// Register access over APB was left to the implementer.
`timescale 1ns/10ps
module smsp_port (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sclk_i,
  output logic sclk_o,
  output logic sclk_oe,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe,
  input wire logic cs_n_i,
  output logic cs_n_o,
  output logic cs_n_oe
);
  function automatic logic [2:0] thr_bytes(input logic [1:0] code);
    thr_bytes = {1'b0, code} + 3'h1;
  endfunction : thr_bytes

  function automatic logic map_ok(input logic [31:0] a);
    map_ok = (a == smsp_pkg::STATUS_OFS) || (a == smsp_pkg::RX_OFS) ||
             (a == smsp_pkg::TX_OFS) || (a == smsp_pkg::DIV_OFS) ||
             (a == smsp_pkg::CON_OFS);
  endfunction : map_ok

  logic [15:0] con_reg;
  logic [7:0] div_reg;
  logic [31:0] prdata_reg;
  logic en, master, cpha, cpol, txmode, rflush, tflush;
  logic [1:0] thr;
  assign en = con_reg[smsp_pkg::CON_EN];
  assign master = con_reg[smsp_pkg::CON_MASTER];
  assign cpha = con_reg[smsp_pkg::CON_CPHA];
  assign cpol = con_reg[smsp_pkg::CON_CPOL];
  assign txmode = con_reg[smsp_pkg::CON_TXMODE];
  assign rflush = con_reg[smsp_pkg::CON_RFLUSH];
  assign tflush = con_reg[smsp_pkg::CON_TFLUSH];
  assign thr = con_reg[smsp_pkg::CON_THR_LO +: 2];

  // apb slave: zero wait states
  logic setup, wr_acc, rd_acc, st_rd, rx_rd;
  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !map_ok(paddr);
  assign prdata = prdata_reg;
  assign st_rd = rd_acc && (paddr == smsp_pkg::STATUS_OFS);
  assign rx_rd = rd_acc && (paddr == smsp_pkg::RX_OFS);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      con_reg <= smsp_pkg::CON_RESET;
      div_reg <= smsp_pkg::DIV_RESET;
    end else if (wr_acc) begin
      if (paddr == smsp_pkg::CON_OFS) begin
        con_reg <= pwdata[15:0] & smsp_pkg::CON_WMASK;
      end
      if (paddr == smsp_pkg::DIV_OFS) begin
        div_reg <= pwdata[7:0];
      end
    end
  end

  // fifo state
  logic [1:0] tx_wp_reg, tx_rp_reg, rx_wp_reg, rx_rp_reg;
  logic [2:0] tx_cnt_reg, tx_cnt_d_reg, rx_cnt_reg, rx_cnt_d_reg;
  logic [7:0] tx_head, rx_head, rx_byte;
  logic tx_avail, rx_avail, tx_push, tx_pop, rx_push, rx_pop;
  logic start, slave_load, byte_done, ovf_evt, uf_evt;
  // head word is valid once the count has been non-zero for a cycle
  assign tx_avail = (tx_cnt_reg != 3'h0) && (tx_cnt_d_reg != 3'h0);
  assign rx_avail = (rx_cnt_reg != 3'h0) && (rx_cnt_d_reg != 3'h0);
  assign tx_push = wr_acc && (paddr == smsp_pkg::TX_OFS) && !tflush &&
                   (tx_cnt_reg != 3'(smsp_pkg::FIFO_DEPTH));
  assign tx_pop = start || (slave_load && tx_avail);
  assign rx_push = byte_done && !rflush &&
                   (rx_cnt_reg != 3'(smsp_pkg::FIFO_DEPTH));
  assign ovf_evt = byte_done && !rflush &&
                   (rx_cnt_reg == 3'(smsp_pkg::FIFO_DEPTH));
  assign rx_pop = rx_rd && rx_avail;
  assign uf_evt = slave_load && !tx_avail;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_wp_reg <= 2'h0;
      tx_rp_reg <= 2'h0;
      tx_cnt_reg <= 3'h0;
      tx_cnt_d_reg <= 3'h0;
    end else begin
      tx_cnt_d_reg <= tx_cnt_reg;
      if (tflush) begin
        tx_wp_reg <= 2'h0;
        tx_rp_reg <= 2'h0;
        tx_cnt_reg <= 3'h0;
      end else begin
        tx_wp_reg <= tx_wp_reg + {1'b0, tx_push};
        tx_rp_reg <= tx_rp_reg + {1'b0, tx_pop};
        tx_cnt_reg <= tx_cnt_reg + {2'b0, tx_push} - {2'b0, tx_pop};
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_wp_reg <= 2'h0;
      rx_rp_reg <= 2'h0;
      rx_cnt_reg <= 3'h0;
      rx_cnt_d_reg <= 3'h0;
    end else begin
      rx_cnt_d_reg <= rx_cnt_reg;
      if (rflush) begin
        rx_wp_reg <= 2'h0;
        rx_rp_reg <= 2'h0;
        rx_cnt_reg <= 3'h0;
      end else begin
        rx_wp_reg <= rx_wp_reg + {1'b0, rx_push};
        rx_rp_reg <= rx_rp_reg + {1'b0, rx_pop};
        rx_cnt_reg <= rx_cnt_reg + {2'b0, rx_push} - {2'b0, rx_pop};
      end
    end
  end

  smsp_fifo_mem #(.W(smsp_pkg::BYTE_W), .DEPTH(smsp_pkg::FIFO_DEPTH),
                  .AW(smsp_pkg::FIFO_AW)) u_tx_mem (
    .core_clk(core_clk),
    .rst(rst),
    .wr_en(tx_push),
    .wr_addr(tx_wp_reg),
    .wr_data(pwdata[7:0]),
    .rd_addr(tx_rp_reg),
    .rd_data(tx_head)
  );

  smsp_fifo_mem #(.W(smsp_pkg::BYTE_W), .DEPTH(smsp_pkg::FIFO_DEPTH),
                  .AW(smsp_pkg::FIFO_AW)) u_rx_mem (
    .core_clk(core_clk),
    .rst(rst),
    .wr_en(rx_push),
    .wr_addr(rx_wp_reg),
    .wr_data(rx_byte),
    .rd_addr(rx_rp_reg),
    .rd_data(rx_head)
  );

  // master clock generator and chip select
  smsp_pkg::smsp_mstate_e mstate_reg;
  logic [7:0] hc_reg;
  logic [4:0] edge_cnt_reg;
  logic sclk_reg, cs_n_reg, m_tick;
  assign start = en && master && (mstate_reg == smsp_pkg::M_IDLE) && tx_avail && !tflush;
  assign m_tick = (mstate_reg != smsp_pkg::M_IDLE) && (hc_reg == div_reg);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mstate_reg <= smsp_pkg::M_IDLE;
      hc_reg <= 8'h00;
      edge_cnt_reg <= 5'h00;
      sclk_reg <= 1'b0;
      cs_n_reg <= 1'b1;
    end else if (!(en && master)) begin
      mstate_reg <= smsp_pkg::M_IDLE;
      hc_reg <= 8'h00;
      edge_cnt_reg <= 5'h00;
      sclk_reg <= cpol;
      cs_n_reg <= 1'b1;
    end else begin
      hc_reg <= m_tick ? 8'h00 : hc_reg + 8'h01;
      case (mstate_reg)
        smsp_pkg::M_IDLE: begin
          sclk_reg <= cpol;
          hc_reg <= 8'h00;
          edge_cnt_reg <= 5'h00;
          if (start) begin
            cs_n_reg <= 1'b0;
            mstate_reg <= smsp_pkg::M_XFER;
          end
        end
        smsp_pkg::M_XFER: begin
          if (m_tick) begin
            sclk_reg <= !sclk_reg;
            edge_cnt_reg <= edge_cnt_reg + 5'h01;
            if (edge_cnt_reg == smsp_pkg::EDGES_PER_BYTE - 5'h01) begin
              cs_n_reg <= 1'b1;
              mstate_reg <= smsp_pkg::M_GAP;
            end
          end
        end
        smsp_pkg::M_GAP: begin
          if (m_tick) begin
            mstate_reg <= smsp_pkg::M_IDLE;
          end
        end
        default: begin
          mstate_reg <= smsp_pkg::M_IDLE;
        end
      endcase
    end
  end

  // edge detection for both roles; slave pins are synchronous to core_clk
  logic sclk_prev_reg, cs_prev_reg, s_act, s_edge, cs_fall;
  logic lead, trail, sample_edge, launch_edge, din;
  assign s_act = en && !master && !cs_n_i;
  assign s_edge = s_act && (sclk_i != sclk_prev_reg);
  assign cs_fall = en && !master && cs_prev_reg && !cs_n_i;
  assign lead = master ? (m_tick && mstate_reg == smsp_pkg::M_XFER && sclk_reg == cpol) :
                (s_edge && sclk_prev_reg == cpol);
  assign trail = master ? (m_tick && mstate_reg == smsp_pkg::M_XFER && sclk_reg != cpol) :
                 (s_edge && sclk_prev_reg != cpol);
  assign sample_edge = cpha ? trail : lead;
  assign launch_edge = cpha ? lead : trail;
  assign din = master ? miso_i : mosi_i;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sclk_prev_reg <= 1'b0;
      cs_prev_reg <= 1'b1;
    end else begin
      sclk_prev_reg <= sclk_i;
      cs_prev_reg <= cs_n_i;
    end
  end

  // shift engine
  logic [2:0] bit_cnt_reg;
  logic [6:0] rx_sh_reg;
  logic [7:0] tx_sh_reg, s_byte;
  logic out_bit_reg;
  assign s_byte = tx_avail ? tx_head : smsp_pkg::UNDERFLOW_BYTE;
  assign slave_load = (cs_fall && !cpha) ||
                      (!master && launch_edge && bit_cnt_reg == 3'h0);
  assign byte_done = sample_edge && (bit_cnt_reg == 3'h7);
  assign rx_byte = {rx_sh_reg, din};

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bit_cnt_reg <= 3'h0;
      rx_sh_reg <= 7'h00;
      tx_sh_reg <= 8'h00;
      out_bit_reg <= 1'b0;
    end else if (start) begin
      bit_cnt_reg <= 3'h0;
      if (cpha) begin
        tx_sh_reg <= tx_head;
      end else begin
        out_bit_reg <= tx_head[7];
        tx_sh_reg <= {tx_head[6:0], 1'b0};
      end
    end else if (!master && cs_n_i) begin
      bit_cnt_reg <= 3'h0;
    end else begin
      if (sample_edge) begin
        rx_sh_reg <= rx_byte[6:0];
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
      end
      if (slave_load) begin
        out_bit_reg <= s_byte[7];
        tx_sh_reg <= {s_byte[6:0], 1'b0};
      end else if (launch_edge && (cpha || bit_cnt_reg != 3'h0)) begin
        out_bit_reg <= tx_sh_reg[7];
        tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
      end
    end
  end

  // pins
  assign sclk_o = sclk_reg;
  assign sclk_oe = en && master;
  assign mosi_o = out_bit_reg;
  assign mosi_oe = en && master;
  assign miso_o = out_bit_reg;
  assign miso_oe = en && !master;
  assign cs_n_o = cs_n_reg;
  assign cs_n_oe = en && master;

  // event flags: a set wins over the read clear; only captured bits clear
  logic [2:0] tx_sent_reg;
  logic ovf_reg, rxirq_reg, txirq_reg, txuf_reg, any_reg;
  logic rex, rxirq_evt, txirq_evt, any_evt;
  logic [31:0] status_word;
  assign rex = rx_cnt_reg > thr_bytes(thr);
  assign rxirq_evt = !txmode && rx_push &&
                     (rx_cnt_reg + 3'h1 >= thr_bytes(thr));
  assign txirq_evt = txmode && byte_done &&
                     (tx_sent_reg + 3'h1 == thr_bytes(thr));
  assign any_evt = !rflush && (ovf_evt || rxirq_evt || txirq_evt ||
                               (uf_evt && !tflush));
  assign status_word = {16'h0000, 4'h0, rex, rx_cnt_reg, ovf_reg, rxirq_reg, txirq_reg,
                        txuf_reg, tx_cnt_reg, any_reg};

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_sent_reg <= 3'h0;
    end else if (!txmode) begin
      tx_sent_reg <= 3'h0;
    end else if (byte_done) begin
      tx_sent_reg <= txirq_evt ? 3'h0 : tx_sent_reg + 3'h1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ovf_reg <= 1'b0;
      rxirq_reg <= 1'b0;
      txirq_reg <= 1'b0;
      txuf_reg <= 1'b0;
      any_reg <= 1'b0;
    end else begin
      ovf_reg <= ovf_evt || (ovf_reg && !(st_rd && prdata_reg[smsp_pkg::ST_OVF]));
      rxirq_reg <= rxirq_evt ||
                   (rxirq_reg && !(st_rd && prdata_reg[smsp_pkg::ST_RXIRQ]));
      txirq_reg <= txirq_evt ||
                   (txirq_reg && !(st_rd && prdata_reg[smsp_pkg::ST_TXIRQ]));
      txuf_reg <= uf_evt || (txuf_reg && !(st_rd && prdata_reg[smsp_pkg::ST_TXUF]));
      any_reg <= any_evt || (any_reg && !(st_rd && prdata_reg[smsp_pkg::ST_ANY]));
    end
  end

  // read data captured in setup phase, before any clear
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      prdata_reg <= smsp_pkg::STATUS_RESET;
    end else if (setup && !pwrite) begin
      case (paddr)
        smsp_pkg::STATUS_OFS: prdata_reg <= status_word;
        smsp_pkg::RX_OFS: prdata_reg <= rx_avail ? {24'h000000, rx_head} : 32'h00000000;
        smsp_pkg::DIV_OFS: prdata_reg <= {24'h000000, div_reg};
        smsp_pkg::CON_OFS: prdata_reg <= {16'h0000, con_reg};
        default: prdata_reg <= 32'h00000000;
      endcase
    end
  end

  // checks
  logic [4:0] tog_cnt_reg;
  logic [7:0] hold_cnt_reg;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tog_cnt_reg <= 5'h00;
      hold_cnt_reg <= 8'h00;
    end else begin
      tog_cnt_reg <= start ? 5'h00 : tog_cnt_reg + {4'h0, lead || trail};
      // two below the cycles spent at the present clock level
      hold_cnt_reg <= start ? 8'hFF :
                      (sclk_reg != sclk_prev_reg) ? 8'h00 : hold_cnt_reg + 8'h01;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  msb_first_a: assert property (start && !cpha |=> mosi_o == $past(tx_head[7]))
    else $error("first bit is not the msb");
  miso_dir_a: assert property (en && !master |-> miso_oe && !mosi_oe && !sclk_oe)
    else $error("slave pin directions wrong");
  mosi_dir_a: assert property (en && master |-> mosi_oe && sclk_oe && !miso_oe)
    else $error("master pin directions wrong");
  byte_edges_a: assert property (master && $rose(mstate_reg == smsp_pkg::M_GAP)
    |-> tog_cnt_reg == 5'h10)
    else $error("byte did not take sixteen clock edges");
  sclk_rate_a: assert property (master && mstate_reg == smsp_pkg::M_XFER &&
    $changed(div_reg) == 1'b0 && hold_cnt_reg > 8'h00 && m_tick
    |-> hold_cnt_reg + 8'h01 == div_reg)
    else $error("half period is not divider plus one");
  cs_start_a: assert property (start |=> !cs_n_o ##0 mstate_reg == smsp_pkg::M_XFER)
    else $error("chip select not low at start");
  cs_end_a: assert property ($rose(mstate_reg == smsp_pkg::M_GAP) |-> cs_n_o)
    else $error("chip select not high after byte");
  slave_idle_a: assert property (en && !master && cs_n_i |=> bit_cnt_reg == 3'h0)
    else $error("slave counts bits with chip select high");
  ovf_flag_a: assert property (ovf_evt |=> ovf_reg && any_reg && $stable(rx_cnt_reg))
    else $error("overflow not flagged");
  txflush_a: assert property (tflush |=> tx_cnt_reg == 3'h0 && !tx_push)
    else $error("transmit flush did not empty fifo");
  rxflush_a: assert property (rflush |-> !rx_push && !any_evt)
    else $error("receive flush let data or events through");
  rd_clear_a: assert property (setup && !pwrite && paddr == smsp_pkg::STATUS_OFS &&
    any_reg ##1 st_rd && !any_evt |=> !any_reg)
    else $error("status read did not clear flag");
  levels_a: assert property (setup && !pwrite && paddr == smsp_pkg::STATUS_OFS
    |=> prdata[10:8] == $past(rx_cnt_reg) && prdata[15:12] == 4'h0)
    else $error("status level field wrong");
  rex_a: assert property (rx_cnt_reg <= 3'h4 &&
    (rex == (rx_cnt_reg > {1'b0, thr} + 3'h1)))
    else $error("excess flag does not match level");

  master_byte_c: cover property (master && $rose(mstate_reg == smsp_pkg::M_GAP));
  slave_byte_c: cover property (!master && rx_push);
  overflow_c: cover property (ovf_evt);
  status_read_c: cover property (st_rd && prdata[smsp_pkg::ST_ANY]);
endmodule : smsp_port

// ===== verification/smsp_slave_model.sv
`timescale 1ns/10ps
module smsp_slave_model (
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic [7:0] got,
  output logic [7:0] cnt
);
  logic [7:0] sh = 8'h00;
  logic [7:0] in_sh = 8'h00;
  logic [3:0] nbit = 4'h0;
  initial begin
    miso = 1'b0;
    got = 8'h00;
    cnt = 8'h00;
  end
  // reply byte ready before the first rising edge, msb first
  always @(negedge cs_n) begin
    sh = 8'h3C ^ (cnt * 8'h1D);
    nbit = 4'h0;
    miso = sh[7];
  end
  always @(posedge sclk) begin
    if (!cs_n) begin
      in_sh = {in_sh[6:0], mosi};
      nbit = nbit + 4'h1;
      if (nbit == 4'h8) begin
        got = in_sh;
        cnt = cnt + 8'h01;
      end
    end
  end
  always @(negedge sclk) begin
    if (!cs_n) begin
      sh = {sh[6:0], 1'b0};
      miso = sh[7];
    end
  end
  // deselected line shows the inverse of its last bit
  always @(posedge cs_n) miso = ~miso;
endmodule : smsp_slave_model

// ===== verification/testbench.sv
`timescale 1ns/10ps
module testbench;
  logic core_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata, rv, ctl, div, per, rises;
  logic sclk_o, sclk_oe, mosi_o, mosi_oe, miso_o, miso_oe, cs_n_o, cs_n_oe, ev;
  logic tb_sclk, tb_cs, tb_mosi, pm_miso, last_sclk, last_cs, txm, rfl;
  logic [7:0] pm_got, pm_cnt, k, sb, mb, gb;
  logic [1:0] thr;
  logic [7:0] txq[$];
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;
  wire sclk_w = sclk_oe ? sclk_o : tb_sclk;
  wire cs_w = cs_n_oe ? cs_n_o : tb_cs;
  wire mosi_w = mosi_oe ? mosi_o : tb_mosi;
  wire miso_w = miso_oe ? miso_o : pm_miso;
  smsp_port smsp_port_inst (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sclk_i(sclk_w), .sclk_o(sclk_o), .sclk_oe(sclk_oe), .mosi_i(mosi_w),
    .mosi_o(mosi_o), .mosi_oe(mosi_oe), .miso_i(miso_w), .miso_o(miso_o), .miso_oe(miso_oe),
    .cs_n_i(cs_w), .cs_n_o(cs_n_o), .cs_n_oe(cs_n_oe));
  smsp_slave_model smsp_slave_model_inst (.sclk(sclk_w), .cs_n(cs_w), .mosi(mosi_w),
    .miso(pm_miso), .got(pm_got), .cnt(pm_cnt));
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic print_verdict;
    $display("errors %0d checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict
  task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk_reg
  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    chk_reg({24'h0, g}, {24'h0, e});
  endtask : chk_byte
  task automatic chk_pin(input logic g, input logic e);
    chk_reg({31'h0, g}, {31'h0, e});
  endtask : chk_pin
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk_reg(rv, e);
  endtask : rd_chk
  task automatic tx_byte(input logic keep);
    sb = 8'($urandom);
    apb(1'b1, smsp_pkg::TX_OFS, {24'h0, sb});
    if (keep) txq.push_back(sb);
  endtask : tx_byte
  task automatic wait_bytes(input logic [7:0] n);
    for (int i = 0; i < 4000 && pm_cnt != n; i++) @(posedge core_clk);
    for (int i = 0; i < 100 && cs_n_o !== 1'b1; i++) @(posedge core_clk);
  endtask : wait_bytes
  task automatic slave_xfer(input logic ph, input logic [7:0] m, output logic [7:0] g);
    @(posedge core_clk);
    tb_cs <= 1'b0;
    repeat (2) @(posedge core_clk);
    for (int i = 7; i >= 0; i--) begin
      if (ph) tb_sclk <= 1'b0;
      tb_mosi <= m[i];
      repeat (4) @(posedge core_clk);
      g[i] = miso_w;
      tb_sclk <= 1'b1;
      repeat (4) @(posedge core_clk);
      if (!ph) tb_sclk <= 1'b0;
    end
    repeat (4) @(posedge core_clk);
    tb_cs <= 1'b1;
    tb_mosi <= ~m[0];
  endtask : slave_xfer
  function automatic logic [31:0] exp_st(logic [1:0] t, logic tm, logic rf, logic first);
    logic [31:0] s;
    logic [2:0] lvl;
    lvl = rf ? 3'h0 : 3'h4;
    s = {20'h0, lvl > ({1'b0, t} + 3'h1), lvl, 8'h00};
    if (first) s = s | {24'h0, ~rf, ~rf & ~tm, tm, 4'h0, ~rf | tm};
    return s;
  endfunction : exp_st
  always @(pm_cnt) if (txq.size() != 0) chk_byte(pm_got, txq.pop_front());
  // serial clock period and rising edges per chip-select window
  always @(negedge core_clk) begin
    if (sclk_oe === 1'b1 && sclk_o === 1'b1 && last_sclk === 1'b0) begin
      if (rises != 0) chk_reg(per, (div + 1) * 2);
      chk_pin(cs_n_o, 1'b0);
      per <= 32'h1;
      rises <= rises + 1;
    end else per <= per + 1;
    if (sclk_oe === 1'b1 && cs_n_o === 1'b1 && last_cs === 1'b0) begin
      chk_reg(rises, 32'h8);
      rises <= 32'h0;
    end
    last_sclk <= sclk_o;
    last_cs <= cs_n_o;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_count++;
      print_verdict;
    end
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, tb_sclk, tb_mosi} = '0;
    {rst, tb_cs, last_cs} = 3'b111;
    {last_sclk, per, rises, k, div} = '0;
    void'($urandom(7));
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    rd_chk(smsp_pkg::STATUS_OFS, smsp_pkg::STATUS_RESET);
    rd_chk(smsp_pkg::CON_OFS, {16'h0, smsp_pkg::CON_RESET});
    rd_chk(smsp_pkg::DIV_OFS, {24'h0, smsp_pkg::DIV_RESET});
    rd_chk(smsp_pkg::STATUS_OFS + 32'h40, 32'h0);
    chk_pin(ev, 1'b1);
    apb(1'b1, smsp_pkg::CON_OFS, 32'h2000);
    tx_byte(1'b0);
    rd_chk(smsp_pkg::STATUS_OFS, 32'h0);
    rd_chk(smsp_pkg::CON_OFS, 32'h2000);
    for (int r = 0; r < 5; r++) begin
      thr = 2'(r);
      txm = r[0] && r < 4;
      rfl = (r == 4);
      ctl = {16'h0, thr, 1'b0, rfl, 5'h0, txm, 5'h1, 1'b0};
      div = $urandom % 4;
      apb(1'b1, smsp_pkg::CON_OFS, ctl);
      apb(1'b1, smsp_pkg::DIV_OFS, div);
      for (int i = 0; i < 5; i++) tx_byte(i < 4);
      rd_chk(smsp_pkg::STATUS_OFS, 32'h8);
      apb(1'b1, smsp_pkg::CON_OFS, ctl | 32'h1);
      @(negedge core_clk);
      chk_pin(sclk_oe & mosi_oe & cs_n_oe & ~miso_oe, 1'b1);
      wait_bytes(k + 8'h4);
      tx_byte(1'b1);
      wait_bytes(k + 8'h5);
      rd_chk(smsp_pkg::STATUS_OFS, exp_st(thr, txm, rfl, 1'b1));
      rd_chk(smsp_pkg::STATUS_OFS, exp_st(thr, txm, rfl, 1'b0));
      for (int i = 0; i < 4 && !rfl; i++) begin
        rd_chk(smsp_pkg::RX_OFS, {24'h0, 8'h3C ^ ((k + 8'(i)) * 8'h1D)});
      end
      rd_chk(smsp_pkg::RX_OFS, 32'h0);
      apb(1'b1, smsp_pkg::CON_OFS, 32'h0);
      k = k + 8'h5;
    end
    apb(1'b1, smsp_pkg::CON_OFS, 32'h1);
    tx_byte(1'b0);
    chk_pin(miso_oe & ~mosi_oe & ~sclk_oe & ~cs_n_oe, 1'b1);
    mb = 8'($urandom);
    slave_xfer(1'b0, mb, gb);
    chk_byte(gb, sb);
    rd_chk(smsp_pkg::STATUS_OFS, 32'h151);
    rd_chk(smsp_pkg::RX_OFS, {24'h0, mb});
    // slave with inverted idle clock, launch on leading edge
    apb(1'b1, smsp_pkg::CON_OFS, 32'hD);
    tx_byte(1'b0);
    tb_sclk <= 1'b1;
    mb = 8'($urandom);
    slave_xfer(1'b1, mb, gb);
    chk_byte(gb, sb);
    rd_chk(smsp_pkg::STATUS_OFS, 32'h141);
    rd_chk(smsp_pkg::RX_OFS, {24'h0, mb});
    print_verdict;
  end
endmodule : testbench
